// [verification/accel_bias_filter_chk.sv]
`timescale 1ns/100ps
module accel_bias_filter_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  input wire logic RD_VALID,
  input wire logic [15:0] RD_DATA,
  input wire logic [1:0] RANGE_MODEL,
  // sample path
  input wire logic SAMPLE_VALID,
  input wire logic OUT_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // a read command, bit 8 ignored on reads
  wire logic rd = CMD_VALID && !CMD_WORD[15];
  ////////////////////////////////////
  rd_answer_a: assert property (
    rd |=> RD_VALID) else $error("read not answered");
  rd_cause_a: assert property (
    RD_VALID |-> $past(rd)) else $error("answer without read");
  wr_silent_a: assert property (
    CMD_VALID && CMD_WORD[15] |=> !RD_VALID) else $error("write answered");
  rd_hold_a: assert property (
    !RD_VALID |-> $stable(RD_DATA)) else $error("read data moved");
  // strap taken at the command edge, so compare with its past value
  range_id_a: assert property (
    rd && CMD_WORD[14:9] == 6'h2F |=>
    RD_DATA == {12'h000, $past(RANGE_MODEL), 2'h3}) else $error("bad id");
  filt_unused_a: assert property (
    rd && CMD_WORD[14:9] == 6'h2E |=> RD_DATA[15:3] == 13'h0000)
    else $error("filter size unused bits set");
  out_lat_a: assert property (
    SAMPLE_VALID |-> ##5 OUT_VALID) else $error("output latency");
  out_cause_a: assert property (
    OUT_VALID |-> $past(SAMPLE_VALID, 5)) else $error("stray output");
endmodule

// [verification/host_model.sv]
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic CLK,
  // command side
  output logic CMD_VALID,
  output logic [15:0] CMD_WORD,
  // answer side
  input wire logic RD_VALID,
  input wire logic [15:0] RD_DATA
);
  initial begin
    CMD_VALID = 1'b0;
    CMD_WORD = 16'h0000;
  end
  // one-cycle strobe; word inverted after so stale bits are never reused
  task automatic send(input logic [15:0] w, output logic [15:0] d);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_WORD = w;
    @(negedge CLK);
    CMD_VALID = 1'b0;
    CMD_WORD = ~w;
    d = RD_VALID ? RD_DATA : 16'hXXXX;
  endtask
endmodule

// [verification/tb_accel_bias_filter.sv]
`timescale 1ns/100ps
module tb_accel_bias_filter;
  import imu_bias_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, SAMPLE_VALID = 1'b0;
  logic CMD_VALID, RD_VALID, OUT_VALID;
  logic [1:0] RANGE_MODEL = 2'h0;
  logic [15:0] CMD_WORD, RD_DATA, d;
  logic [SAMPLE_W-1:0] ain [3], aout [3];
  int failures = 0, cmp_count = 0, cycles = 0, seed = 1;
  int rm [64];
  longint h1 [3][$], h2 [3][$];
  always #12.5 CLK = ~CLK;
  accel_bias_filter u_dut (.CLK, .RST_N, .CMD_VALID, .CMD_WORD, .RD_VALID,
    .RD_DATA, .RANGE_MODEL, .SAMPLE_VALID, .ACCEL_X_IN(ain[0]),
    .ACCEL_Y_IN(ain[1]), .ACCEL_Z_IN(ain[2]), .OUT_VALID,
    .ACCEL_X_OUT(aout[0]), .ACCEL_Y_OUT(aout[1]), .ACCEL_Z_OUT(aout[2]));
  host_model u_host (.CLK, .CMD_VALID, .CMD_WORD, .RD_VALID, .RD_DATA);
  ////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // model word read; id upper bits read zero
  function automatic logic [15:0] ex(input int a);
    return (a >> 1 == 47) ? {12'h000, RANGE_MODEL, 2'h3} : 16'(rm[a >> 1]);
  endfunction
  // byte writes land alone; low filter byte restarts the history
  task automatic wr(input int a, input int v);
    u_host.send({1'b1, 7'(a), 8'(v)}, d);
    if ((a >> 1) inside {[38:43]})
      rm[a >> 1][(a % 2) * 8 +: 8] = v[7:0];
    if (a == 8'h5C) begin
      rm[46] = v & 7;
      for (int k = 0; k < 3; k++) begin
        h1[k] = {};
        h2[k] = {};
      end
    end
  endtask
  task automatic rd(input int a);
    u_host.send({1'b0, 7'(a), 8'h00}, d);
    chk(d, ex(a));
  endtask
  // two averaging stages, missing history counts as zero
  task automatic smp();
    int n, bi;
    longint s;
    logic [31:0] e [3];
    n = 1 << rm[46];
    @(negedge CLK);
    for (int k = 0; k < 3; k++) begin
      ain[k] = $random(seed);
      bi = ain[k] + {rm[39 + 2 * k][15:0], rm[38 + 2 * k][15:0]};
      h1[k].push_front(bi);
      if (h1[k].size() > n) void'(h1[k].pop_back());
      s = h1[k].sum() >>> rm[46];
      h2[k].push_front(s);
      if (h2[k].size() > n) void'(h2[k].pop_back());
      e[k] = 32'(h2[k].sum() >>> rm[46]);
    end
    SAMPLE_VALID = 1'b1;
    @(negedge CLK);
    SAMPLE_VALID = 1'b0;
    repeat (5) @(negedge CLK);
    for (int k = 0; k < 3; k++) chk(aout[k], e[k]);
  endtask
  ////////////////////////////////////
  initial begin
    for (int k = 0; k < 3; k++) ain[k] = '0;
    rm = '{default: 0};
    repeat (6) @(posedge CLK);
    @(negedge CLK) RST_N = 1'b1;
    for (int a = 8'h4A; a < 8'h62; a += 2) rd(a);
    // every byte, holes and read-only included, then read through odd
    for (int a = 8'h4C; a < 8'h60; a++) wr(a, $random(seed));
    for (int a = 8'h4B; a < 8'h60; a += 2) rd(a);
    for (int r = 0; r < 4; r++) begin
      RANGE_MODEL = 2'(r);
      rd(8'h5E);
    end
    wr(8'h5C, 8'h04);
    wr(8'h5D, 8'h00);
    rd(8'h5C);
    wr(8'h5C, 8'hFF);
    rd(8'h5D);
    // every size; the widest runs past its window so both stages drop
    // old taps through the wrapped history address
    for (int b = 0; b < 8; b++) begin
      wr(8'h4C + b, $random(seed));
      wr(8'h5C, b);
      repeat (b == 7 ? 140 : 10) smp();
    end
    results();
  end
  // hang guard, well above the roughly 1600 cycles needed
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
endmodule
bind accel_bias_filter accel_bias_filter_chk u_chk (.CLK, .RST_N,
  .CMD_VALID, .CMD_WORD, .RD_VALID, .RD_DATA, .RANGE_MODEL,
  .SAMPLE_VALID, .OUT_VALID);

// [verilog/accel_bias_filter.sv]
`timescale 1ns/100ps
// Contract
// - x accel bias is 32 bits: low word 0x4C/0x4D, high word 0x4E/0x4F.
// - y accel bias is 32 bits: low word 0x50/0x51, high 0x52/0x53.
// - z accel bias is 32 bits: low word 0x54/0x55, high 0x56/0x57.
// - high word is upper half of the 32-bit bias in output format.
// - bias words are read/write, reset to zero, kept in backup; here every RST_N clears them to zero, no backup is kept.
// - filter size bits 2:0 give B, each stage averages 2^B samples.
// - two cascaded equal moving averages form a triangular FIR.
// - cascade delays the output by about N input samples.
// - range id at 0x5E read-only, bits 3:2 report gyro range.
// - range id bits 1:0 always read binary 11.
// - user bias is added right after factory correction, 2 kHz chain.
module accel_bias_filter
  import imu_bias_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // command port
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  output logic RD_VALID,
  output logic [15:0] RD_DATA,
  // model straps
  input wire logic [1:0] RANGE_MODEL,
  // factory-corrected samples
  input wire logic SAMPLE_VALID,
  input wire logic [imu_bias_pkg::SAMPLE_W-1:0] ACCEL_X_IN,
  input wire logic [imu_bias_pkg::SAMPLE_W-1:0] ACCEL_Y_IN,
  input wire logic [imu_bias_pkg::SAMPLE_W-1:0] ACCEL_Z_IN,
  // filtered output
  output logic OUT_VALID,
  output logic [imu_bias_pkg::SAMPLE_W-1:0] ACCEL_X_OUT,
  output logic [imu_bias_pkg::SAMPLE_W-1:0] ACCEL_Y_OUT,
  output logic [imu_bias_pkg::SAMPLE_W-1:0] ACCEL_Z_OUT
);

  import imu_bias_pkg::*;

  typedef struct packed {
    logic [BIAS_WORDS-1:0][15:0] bias;
    logic [FILT_B_W-1:0] size_b;
    filt_state_e state;
    logic [HIST_AW-1:0] ptr;
    logic [HIST_AW:0] fill;
    logic [AXES-1:0][SUM_W-1:0] sum1;
    logic [AXES-1:0][SUM_W-1:0] sum2;
    logic [AXES-1:0][SAMPLE_W-1:0] work;
    logic [AXES-1:0][SAMPLE_W-1:0] dout;
    logic out_valid;
    logic rd_valid;
    logic [15:0] rd_data;
  } state_s;

  state_s r_reg;
  state_s r_next;

  logic [AXES-1:0][SAMPLE_W-1:0] sample_in;
  logic [AXES-1:0][SAMPLE_W-1:0] mem_rdata;
  logic [HIST_AW:0] taps;
  logic window_full;
  logic mem_we;
  logic mem_stage;
  logic [MEM_AW-1:0] mem_waddr;
  logic [MEM_AW-1:0] mem_raddr;
  logic [5:0] cmd_waddr;
  logic [15:0] rd_word;
  logic [SUM_W-1:0] old_ext;
  logic [SUM_W-1:0] new_ext;

  assign sample_in = {ACCEL_Z_IN, ACCEL_Y_IN, ACCEL_X_IN};
  assign cmd_waddr = CMD_WORD[CMD_WADDR_HI:CMD_WADDR_LO];

  //////////////////////////////////////////////////////////////////////////
  // history addressing; 7-bit wrap makes 128 taps read the slot being
  // overwritten, which the read-first memory still returns intact
  always_comb begin
    taps = (HIST_AW+1)'(1) << r_reg.size_b;
    window_full = r_reg.fill >= taps;
    mem_stage = (r_reg.state == ST_RD2);
    mem_we = (r_reg.state == ST_RD1) || (r_reg.state == ST_RD2);
    mem_waddr = {mem_stage, r_reg.ptr};
    mem_raddr = {mem_stage, r_reg.ptr - taps[HIST_AW-1:0]};
  end

  // one history memory per axis, both stages share it by the top bit
  for (genvar a = 0; a < AXES; a++) begin : g_hist
    avg_history_mem u_hist (
      .CLK(CLK),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(r_reg.work[a]),
      .raddr(mem_raddr),
      .rdata(mem_rdata[a])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux for the register bank
  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < BIAS_WORDS; i++) begin
      if (cmd_waddr == BIAS_ADDR[i][6:1]) begin
        rd_word = r_reg.bias[i];
      end
    end
    if (cmd_waddr == ADDR_FILTER_SIZE[6:1]) begin
      rd_word = {13'h0000, r_reg.size_b};
    end
    if (cmd_waddr == ADDR_RANGE_ID[6:1]) begin
      rd_word = {12'h000, RANGE_MODEL, RANGE_RSVD_BITS};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state: the filter sequencer, then command handling
  always_comb begin
    r_next = r_reg;
    old_ext = '0;
    new_ext = '0;
    r_next.rd_valid = 1'b0;
    r_next.out_valid = 1'b0;

    case (r_reg.state)
      ST_IDLE: begin
        // samples arriving mid-sequence are dropped; at 2 kHz the five
        // cycle sequence is always idle long before the next one
        if (SAMPLE_VALID) begin
          for (int a = 0; a < AXES; a++) begin
            // bias added straight after factory correction
            r_next.work[a] = sample_in[a] + {r_reg.bias[2*a+1],
              r_reg.bias[2*a]};
          end
          r_next.state = ST_RD1;
        end
      end
      ST_RD1: begin
        r_next.state = ST_ACC1;
      end
      ST_ACC1: begin
        for (int a = 0; a < AXES; a++) begin
          old_ext = window_full ? SUM_W'($signed(mem_rdata[a])) : '0;
          new_ext = SUM_W'($signed(r_reg.work[a]));
          r_next.sum1[a] = r_reg.sum1[a] + new_ext - old_ext;
          r_next.work[a] = SAMPLE_W'($signed(r_next.sum1[a]) >>>
            r_reg.size_b);
        end
        r_next.state = ST_RD2;
      end
      ST_RD2: begin
        r_next.state = ST_ACC2;
      end
      ST_ACC2: begin
        // second stage gives the triangle; delay adds up to N
        for (int a = 0; a < AXES; a++) begin
          old_ext = window_full ? SUM_W'($signed(mem_rdata[a])) : '0;
          new_ext = SUM_W'($signed(r_reg.work[a]));
          r_next.sum2[a] = r_reg.sum2[a] + new_ext - old_ext;
          r_next.dout[a] = SAMPLE_W'($signed(r_next.sum2[a]) >>>
            r_reg.size_b);
        end
        r_next.ptr = r_reg.ptr + 1'b1;
        if (!r_reg.fill[HIST_AW]) begin
          r_next.fill = r_reg.fill + 1'b1;
        end
        r_next.out_valid = 1'b1;
        r_next.state = ST_IDLE;
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // command word: writes store one byte, reads answer a whole word
    if (CMD_VALID) begin
      if (CMD_WORD[CMD_WRITE_BIT]) begin
        for (int i = 0; i < BIAS_WORDS; i++) begin
          if (cmd_waddr == BIAS_ADDR[i][6:1]) begin
            if (CMD_WORD[CMD_ODD_BIT]) begin
              r_next.bias[i][15:8] = CMD_WORD[7:0];
            end else begin
              r_next.bias[i][7:0] = CMD_WORD[7:0];
            end
          end
        end
        // high byte holds only unused bits, so it is dropped
        if (cmd_waddr == ADDR_FILTER_SIZE[6:1] &&
            !CMD_WORD[CMD_ODD_BIT]) begin
          r_next.size_b = CMD_WORD[FILT_B_W-1:0];
          // new window length: flush so stale sums never leak through
          r_next.fill = '0;
          r_next.sum1 = '0;
          r_next.sum2 = '0;
        end
      end else begin
        r_next.rd_valid = 1'b1;
        r_next.rd_data = rd_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_reg <= '0;
      r_reg.bias <= {BIAS_WORDS{BIAS_RESET}};
      r_reg.size_b <= FILTER_SIZE_RESET;
      r_reg.state <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign RD_VALID = r_reg.rd_valid;
  assign RD_DATA = r_reg.rd_data;
  assign OUT_VALID = r_reg.out_valid;
  assign ACCEL_X_OUT = r_reg.dout[0];
  assign ACCEL_Y_OUT = r_reg.dout[1];
  assign ACCEL_Z_OUT = r_reg.dout[2];

endmodule

// [verilog/avg_history_mem.sv]
`timescale 1ns/100ps
module avg_history_mem
  import imu_bias_pkg::*;
(
  // clock
  input wire logic CLK,
  // write port
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [SAMPLE_W-1:0] wdata,
  // read port, data registered
  input wire logic [MEM_AW-1:0] raddr,
  output logic [SAMPLE_W-1:0] rdata
);

  logic [SAMPLE_W-1:0] mem [2**MEM_AW];

  // read-first: a same-address write returns the old entry, which is what
  // the averager needs when the window spans the whole history
  always_ff @(posedge CLK) begin
    rdata <= mem[raddr];
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

endmodule

// [verilog/imu_bias_pkg.sv]
package imu_bias_pkg;

  // widths
  localparam int AXES = 3;
  localparam int BIAS_WORDS = 6;
  localparam int SAMPLE_W = 32;
  localparam int SUM_W = 40;
  localparam int HIST_AW = 7;
  localparam int MEM_AW = 8;
  localparam int FILT_B_W = 3;

  ////////////////////////////////////////////////////////////////////////
  // command word layout
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_WADDR_HI = 14;
  localparam int CMD_WADDR_LO = 9;
  localparam int CMD_ODD_BIT = 8;

  ////////////////////////////////////////////////////////////////////////
  // byte addresses, bias words in order x low, x high, y low ... z high
  localparam logic [5:0][6:0] BIAS_ADDR = {
    7'h56, 7'h54, 7'h52, 7'h50, 7'h4E, 7'h4C
  };
  localparam logic [6:0] ADDR_FILTER_SIZE = 7'h5C;
  localparam logic [6:0] ADDR_RANGE_ID = 7'h5E;

  ////////////////////////////////////////////////////////////////////////
  // reset values and fixed fields
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [2:0] FILTER_SIZE_RESET = 3'h0;
  localparam int RANGE_POS = 2;
  localparam logic [1:0] RANGE_RSVD_BITS = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // timing: sample chain rate against the core clock
  localparam int CLK_HZ = 40000000;
  localparam int SAMPLE_RATE_HZ = 2000;
  localparam int CYCLES_PER_SAMPLE = CLK_HZ / SAMPLE_RATE_HZ;

  // filter sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD1 = 3'b001,
    ST_ACC1 = 3'b010,
    ST_RD2 = 3'b011,
    ST_ACC2 = 3'b100
  } filt_state_e;

endpackage
